// *** rtl/mcs_pkg.sv ***
// shared constants and types for the multiplexed-channel sync-frame block
package mcs_pkg;
   // system and link rates
   localparam int unsigned SYS_HZ = 100_000_000;
   localparam int unsigned SYS_PER_MHZ = SYS_HZ / 1_000_000;
   localparam int unsigned LINK_HZ = 100_000;
   localparam int unsigned HALF_CYC = SYS_HZ / (2 * LINK_HZ);
   // least sync gap, as a time and as a count
   localparam int unsigned SYNC_MIN_US = 82;
   localparam int unsigned SYNC_MIN_CYC = SYNC_MIN_US * SYS_PER_MHZ;
   // high time that marks a gap: above a 10 kHz high half, below the least gap
   localparam int unsigned GAP_DET_US = 60;
   localparam int unsigned GAP_DET_CYC = GAP_DET_US * SYS_PER_MHZ;
   // gap of 8.5 link periods, counted in half periods from the closing rising edge
   localparam int unsigned SYNC_HALVES = 17;
   // fault pulse in the second and third gap periods
   localparam int unsigned FAULT_PULSE_DELAY_HALVES = 2;
   localparam int unsigned FAULT_PULSE_LENGTH_HALVES = 4;
   localparam int unsigned FAULT_PULSE_END_HALF = FAULT_PULSE_DELAY_HALVES
      + FAULT_PULSE_LENGTH_HALVES;
   localparam int unsigned FAULT_PULSE_RECOVERY_HALVES = SYNC_HALVES - FAULT_PULSE_END_HALF;
   localparam int unsigned FAULT_PULSE_MARGIN_NS = 500;
   // frame geometry
   localparam int unsigned NSIG = 4;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned CH_W = 4;
   localparam int unsigned PC_W = 10;
   localparam int unsigned HC_W = 10;
   localparam int unsigned HI_W = 16;
   localparam int unsigned CH_FIRST_ADDR = 1;
   localparam int unsigned CH_LAST_ADDR = 4;
   localparam int unsigned LAST_PULSE_PP = 255;
   localparam int unsigned LAST_PULSE_MS = 511;
   typedef enum logic [1:0]
   {
      CS_IDLE = 2'h0,
      CS_LOW = 2'h1,
      CS_HIGH = 2'h3,
      CS_SYNC = 2'h2
   } mcs_cs_state_t;
endpackage

// *** rtl/mcs_sync2.sv ***
// two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ps
module mcs_sync2 #(
   parameter int unsigned W = 2
)(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mcs_sync_reg_t;
   mcs_sync_reg_t r_ff;
   mcs_sync_reg_t nxt_r;

   always_comb
   begin
      nxt_r.s1 = pin_i;
      nxt_r.s2 = r_ff.s1;
   end

   // idle bus lines rest high, so reset to high
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         r_ff <= '1;
      else
         r_ff <= nxt_r;
   end

   assign sync_o = r_ff.s2;
endmodule

// *** rtl/mcs_clk_src.sv ***
// clock-source end: frame pulses, channel bits, sync gap and fault pulse
`timescale 1ns/1ps
module mcs_clk_src (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic run_i,
   input wire logic ms_mode_i,
   input wire logic [mcs_pkg::CH_W-1:0] ch_last_i,
   input wire logic prio_en_i,
   input wire logic [mcs_pkg::CH_W-1:0] prio_ch_i,
   output logic clk_o,
   output logic pull_o
);
   import mcs_pkg::*;

   typedef struct packed
   {
      mcs_cs_state_t st;
      logic [HC_W-1:0] hc;
      logic [PC_W-1:0] pn;
      logic [CH_W-1:0] chan;
      logic [CH_W-1:0] seq;
      logic prio_turn;
      logic clk;
      logic pull;
   } mcs_cs_reg_t;

   mcs_cs_reg_t r_ff;
   mcs_cs_reg_t nxt_r;

   always_comb
   begin
      logic hc_end;
      logic [7:0] addr;
      logic out_slot;
      logic [1:0] idx;
      addr = '0;
      out_slot = 1'b0;
      idx = '0;
      nxt_r = r_ff;
      hc_end = (r_ff.hc == HC_W'(HALF_CYC - 1));
      nxt_r.hc = hc_end ? '0 : HC_W'(r_ff.hc + 1'b1);
      case (r_ff.st)
         CS_IDLE:
         begin
            nxt_r.hc = '0;
            if (run_i)
            begin
               nxt_r.st = CS_SYNC;
               nxt_r.pn = '0;
            end
         end
         CS_SYNC:
         begin
            if (hc_end)
            begin
               if (r_ff.pn == PC_W'(SYNC_HALVES - 1)) // [RL16]
               begin
                  if (!run_i)
                     nxt_r.st = CS_IDLE;
                  else
                  begin
                     nxt_r.st = CS_LOW;
                     nxt_r.pn = '0;
                     // a priority frame between every two sequential ones [RL10]
                     if (prio_en_i && !r_ff.prio_turn)
                     begin
                        nxt_r.chan = prio_ch_i;
                        nxt_r.prio_turn = 1'b1;
                     end
                     else
                     begin
                        nxt_r.chan = r_ff.seq;
                        nxt_r.prio_turn = 1'b0;
                        // ascending with wrap, never past the last used channel [RL10] [RL11]
                        nxt_r.seq = (r_ff.seq >= ch_last_i) ? '0 : CH_W'(r_ff.seq + 1'b1);
                     end
                  end
               end
               else
                  nxt_r.pn = PC_W'(r_ff.pn + 1'b1);
            end
         end
         CS_LOW:
         begin
            if (hc_end)
               nxt_r.st = CS_HIGH;
         end
         CS_HIGH:
         begin
            if (hc_end)
            begin
               if (r_ff.pn == (ms_mode_i ? PC_W'(LAST_PULSE_MS) : PC_W'(LAST_PULSE_PP)))
               begin
                  // the closing high half is the first half of the gap [RL14]
                  nxt_r.st = CS_SYNC;
                  nxt_r.pn = PC_W'(1);
               end
               else
               begin
                  nxt_r.st = CS_LOW;
                  nxt_r.pn = PC_W'(r_ff.pn + 1'b1);
               end
            end
         end
         default:
            nxt_r.st = CS_IDLE;
      endcase
      // line held high through the whole gap [RL15]
      nxt_r.clk = (nxt_r.st != CS_LOW);
      addr = ms_mode_i ? nxt_r.pn[8:1] : nxt_r.pn[7:0];
      out_slot = !ms_mode_i || nxt_r.pn[0];
      idx = 2'(addr[1:0] - 2'h1);
      nxt_r.pull = 1'b0;
      if (nxt_r.st == CS_SYNC)
         nxt_r.pull = (nxt_r.pn >= PC_W'(FAULT_PULSE_DELAY_HALVES))
            && (nxt_r.pn < PC_W'(FAULT_PULSE_END_HALF)); // [RL19] [RL20] [RL21]
      else if (nxt_r.st == CS_LOW && out_slot && addr >= 8'(CH_FIRST_ADDR)
         && addr <= 8'(CH_LAST_ADDR))
         nxt_r.pull = nxt_r.chan[idx]; // [RL4]
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         r_ff <= '0;
         r_ff.clk <= 1'b1;
      end
      else
         r_ff <= nxt_r;
   end

   assign clk_o = r_ff.clk;
   assign pull_o = r_ff.pull;

   property p_sync_clk_high;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (r_ff.st == CS_SYNC) |-> r_ff.clk;
   endproperty
   a_sync_clk_high: assert property (p_sync_clk_high) // [RL15]
      else $error("clock line low inside the sync gap");

   sequence s_fp_start;
      (r_ff.st == CS_SYNC) && $rose(r_ff.pull);
   endsequence
   property p_fp_delay;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      s_fp_start |-> (r_ff.pn == PC_W'(FAULT_PULSE_DELAY_HALVES)) && (r_ff.hc == '0);
   endproperty
   a_fp_delay: assert property (p_fp_delay) // [RL19]
      else $error("fault pulse started before its delay");

   property p_fp_end;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (r_ff.st == CS_SYNC) && $fell(r_ff.pull)
      |-> (r_ff.pn == PC_W'(FAULT_PULSE_END_HALF)) && (r_ff.hc == '0);
   endproperty
   a_fp_end: assert property (p_fp_end) // [RL20]
      else $error("fault pulse length or recovery wrong");

   property p_chan_bit0;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (r_ff.st == CS_LOW) && !ms_mode_i && (r_ff.pn == PC_W'(CH_FIRST_ADDR))
      |-> (r_ff.pull == r_ff.chan[0]);
   endproperty
   a_chan_bit0: assert property (p_chan_bit0) // [RL4]
      else $error("output one does not carry channel bit zero");
endmodule

// *** rtl/mcs_dev.sv ***
// bus device: pulse counting, sync gap detection, channel gating, optional clock source
// Behaviour
// RL1: sixteen channels; one channel per frame.
// RL2: matching channel: read and drive normally.
// RL3: other channel: ignore outputs, never pull line.
// RL4: channel sent binary on outputs one to four.
// RL5: multiplexing covers whole aligned sixteen-address words.
// RL6: word zero is never multiplexed.
// RL7: multiplexing chosen per word, inputs/outputs separately.
// RL8: non-multiplexed signals ignore channel entirely.
// RL9: multiplexed addresses never shared with others.
// RL10: channels ascend and wrap; priority insertion allowed.
// RL11: at most sixteen channels, none outside range.
// RL12: no output device on outputs one-four.
// RL13: each signal has its own channel.
// RL14: gap runs from closing rise to fall.
// RL15: clock held high through whole gap.
// RL16: gap 8.5 periods up to 100 kHz.
// RL17: gap at least 82 us, unlike clock loss.
// RL18: gap clears address counter; watch fault pulse.
// RL19: fault pulse starts a period after rise.
// RL20: fault pulse two periods; two-period recovery.
// RL21: every gap carries one fault pulse.
// RL22: line idles high; low means one.
// RL23: master/slave: two pulses per address.
// RL24: latch channel after output four; hold.
`timescale 1ns/1ps
module mcs_dev #(
   parameter int unsigned GAP_DET_CYC = mcs_pkg::GAP_DET_CYC
)(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic link_clk_i,
   input wire logic data_i,
   input wire logic ms_mode_i,
   input wire logic src_en_i,
   input wire logic [mcs_pkg::CH_W-1:0] ch_last_i,
   input wire logic prio_en_i,
   input wire logic [mcs_pkg::CH_W-1:0] prio_ch_i,
   input wire logic [mcs_pkg::NSIG-1:0][3:0] sig_word_i,
   input wire logic [mcs_pkg::NSIG-1:0] sig_is_out_i,
   input wire logic [mcs_pkg::NSIG-1:0] sig_mux_i,
   input wire logic [mcs_pkg::NSIG-1:0][mcs_pkg::CH_W-1:0] sig_chan_i,
   input wire logic [mcs_pkg::NSIG-1:0][mcs_pkg::WORD_W-1:0] tx_word_i,
   output logic data_o,
   output logic data_oe_n_o,
   output logic link_clk_o,
   output logic link_clk_oe_n_o,
   output logic [mcs_pkg::NSIG-1:0][mcs_pkg::WORD_W-1:0] rx_word_o,
   output logic [mcs_pkg::NSIG-1:0] rx_upd_o,
   output logic [mcs_pkg::CH_W-1:0] chan_o,
   output logic chan_vld_o,
   output logic bus_ok_o
);
   import mcs_pkg::*;

   typedef struct packed
   {
      logic clk_d;
      logic [PC_W-1:0] pc;
      logic [HI_W-1:0] hi_cnt;
      logic in_gap;
      logic synced;
      logic drv;
      logic [CH_W-1:0] chan;
      logic chan_vld;
      logic seen_lo;
      logic seen_rise;
      logic seen_hi;
      logic [NSIG-1:0][WORD_W-1:0] shadow;
      logic [NSIG-1:0][WORD_W-1:0] rx;
      logic [NSIG-1:0] upd;
      logic bus_ok;
      logic data;
      logic data_oe_n;
      logic lclk;
      logic lclk_oe_n;
   } mcs_dev_reg_t;

   mcs_dev_reg_t r_ff;
   mcs_dev_reg_t nxt_r;
   logic [1:0] pins_s;
   logic clk_s;
   logic data_s;
   logic src_clk;
   logic src_pull;
   logic fall_w;
   logic rise_w;
   logic [PC_W-1:0] p_fall;
   logic [7:0] addr_f;
   logic [7:0] addr_c;
   logic in_slot_f;
   logic out_slot_c;
   logic gap_hit_w;
   logic [NSIG-1:0] act_w;
   logic [NSIG-1:0] drv_hit;
   logic [NSIG-1:0] rx_hit;

   mcs_sync2 #(
      .W(2)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i({link_clk_i, data_i}),
      .sync_o(pins_s)
   );

   mcs_clk_src u_src (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .run_i(src_en_i),
      .ms_mode_i(ms_mode_i),
      .ch_last_i(ch_last_i),
      .prio_en_i(prio_en_i),
      .prio_ch_i(prio_ch_i),
      .clk_o(src_clk),
      .pull_o(src_pull)
   );

   assign clk_s = pins_s[1];
   assign data_s = pins_s[0];
   assign fall_w = r_ff.clk_d && !clk_s;
   assign rise_w = !r_ff.clk_d && clk_s;
   // first pulse after a gap is number zero [RL18]
   assign p_fall = r_ff.in_gap ? '0 : PC_W'(r_ff.pc + 1'b1);
   // master/slave halves the pulse count; even pulse is the input slot [RL23]
   assign addr_f = ms_mode_i ? p_fall[8:1] : p_fall[7:0];
   assign addr_c = ms_mode_i ? r_ff.pc[8:1] : r_ff.pc[7:0];
   assign in_slot_f = !ms_mode_i || !p_fall[0];
   assign out_slot_c = !ms_mode_i || r_ff.pc[0];
   assign gap_hit_w = clk_s && !rise_w && !r_ff.in_gap
      && (r_ff.hi_cnt == HI_W'(GAP_DET_CYC - 1));

   for (genvar s = 0; s < NSIG; s++)
   begin : g_sig
      // a non-multiplexed signal or one in word zero is never gated; multiplexed others by their own channel
      assign act_w[s] = !(sig_mux_i[s] && (sig_word_i[s] != 4'h0))
         || (r_ff.chan_vld && (r_ff.chan == sig_chan_i[s])); // [RL2] [RL5] [RL6] [RL8] [RL13]
      assign drv_hit[s] = !sig_is_out_i[s] && (sig_word_i[s] == addr_f[7:4])
         && act_w[s] && tx_word_i[s][addr_f[3:0]]; // [RL3] [RL7]
      assign rx_hit[s] = sig_is_out_i[s] && (sig_word_i[s] == addr_c[7:4])
         && act_w[s]; // [RL3] [RL7]
   end

   always_comb
   begin
      logic [1:0] cidx;
      nxt_r = r_ff;
      cidx = 2'(addr_c[1:0] - 2'h1);
      nxt_r.clk_d = clk_s;
      nxt_r.upd = '0;
      if (fall_w)
      begin
         nxt_r.pc = p_fall;
         nxt_r.in_gap = 1'b0;
         // pull low only for a one in our own active input slot [RL22] [RL3]
         nxt_r.drv = r_ff.synced && in_slot_f && (|drv_hit);
         if (r_ff.in_gap)
            nxt_r.bus_ok = r_ff.seen_lo && r_ff.seen_rise; // [RL18]
      end
      else if (rise_w)
      begin
         // released once the rising edge has sampled the bit
         nxt_r.drv = 1'b0;
         nxt_r.hi_cnt = '0;
         nxt_r.seen_lo = 1'b0;
         nxt_r.seen_rise = 1'b0;
         nxt_r.seen_hi = 1'b0;
         if (r_ff.synced && out_slot_c)
         begin
            if (addr_c >= 8'(CH_FIRST_ADDR) && addr_c <= 8'(CH_LAST_ADDR))
               nxt_r.chan[cidx] = !data_s; // [RL4] [RL1]
            if (addr_c == 8'(CH_LAST_ADDR))
               nxt_r.chan_vld = 1'b1; // [RL24]
            for (int s = 0; s < NSIG; s++)
            begin
               if (rx_hit[s])
                  nxt_r.shadow[s][addr_c[3:0]] = !data_s; // [RL22]
            end
         end
      end
      else if (clk_s)
      begin
         if (r_ff.hi_cnt != '1)
            nxt_r.hi_cnt = HI_W'(r_ff.hi_cnt + 1'b1); // [RL14]
         // high, low, high again while the clock rests high is the fault pulse;
         // a low counts only after a high, so a late release after the rise is no pulse
         if (!data_s)
         begin
            if (r_ff.seen_hi)
               nxt_r.seen_lo = 1'b1;
         end
         else
         begin
            nxt_r.seen_hi = 1'b1;
            if (r_ff.seen_lo)
               nxt_r.seen_rise = 1'b1; // [RL18]
         end
         if (gap_hit_w)
         begin
            // high longer than any 10 kHz half period yet short of 82 us [RL17]
            nxt_r.in_gap = 1'b1;
            nxt_r.synced = 1'b1;
            nxt_r.pc = '0; // [RL18]
            nxt_r.chan_vld = 1'b0; // [RL24]
            for (int s = 0; s < NSIG; s++)
            begin
               if (r_ff.synced && sig_is_out_i[s] && act_w[s])
               begin
                  nxt_r.rx[s] = r_ff.shadow[s]; // [RL2] [RL8]
                  nxt_r.upd[s] = 1'b1;
               end
            end
         end
      end
      // open-drain data: only ever driven low
      nxt_r.data = 1'b0;
      nxt_r.data_oe_n = !(nxt_r.drv || (src_en_i && src_pull)); // [RL21]
      nxt_r.lclk = src_clk; // [RL15]
      nxt_r.lclk_oe_n = !src_en_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         r_ff <= '0;
         r_ff.clk_d <= 1'b1;
         r_ff.data_oe_n <= 1'b1;
         r_ff.lclk <= 1'b1;
         r_ff.lclk_oe_n <= 1'b1;
      end
      else
         r_ff <= nxt_r;
   end

   assign data_o = r_ff.data;
   assign data_oe_n_o = r_ff.data_oe_n;
   assign link_clk_o = r_ff.lclk;
   assign link_clk_oe_n_o = r_ff.lclk_oe_n;
   assign rx_word_o = r_ff.rx;
   assign rx_upd_o = r_ff.upd;
   assign chan_o = r_ff.chan;
   assign chan_vld_o = r_ff.chan_vld;
   assign bus_ok_o = r_ff.bus_ok;

   property p_gap_clears;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(r_ff.in_gap) |-> (r_ff.pc == '0) && !r_ff.chan_vld && r_ff.synced;
   endproperty
   a_gap_clears: assert property (p_gap_clears) // [RL18]
      else $error("gap did not clear the address counter");

   property p_gap_time;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(r_ff.in_gap) |-> ($past(r_ff.hi_cnt) == HI_W'(GAP_DET_CYC - 1)) && $past(clk_s);
   endproperty
   a_gap_time: assert property (p_gap_time) // [RL17]
      else $error("gap taken at the wrong high time");

   property p_drive_on_fall;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(r_ff.drv) |-> $past(fall_w) && $past(r_ff.synced);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) // [RL22]
      else $error("data drive began away from a falling edge");

   sequence s_rise_seen;
      rise_w;
   endsequence
   sequence s_released;
      ##1 (!r_ff.drv) ##1 r_ff.data_oe_n || (src_en_i && src_pull);
   endsequence
   property p_release;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      s_rise_seen |-> s_released;
   endproperty
   a_release: assert property (p_release) // [RL22]
      else $error("data line not released after the rising edge");

   property p_upd_gated;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      (r_ff.upd != '0) |-> ((r_ff.upd & ~$past(act_w)) == '0)
         && ((r_ff.upd & ~sig_is_out_i) == '0);
   endproperty
   a_upd_gated: assert property (p_upd_gated) // [RL3]
      else $error("word delivered for an inactive channel");

   property p_chan_latch;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(r_ff.chan_vld) |-> $past(rise_w) && ($past(addr_c) == 8'(CH_LAST_ADDR))
         && $past(out_slot_c);
   endproperty
   a_chan_latch: assert property (p_chan_latch) // [RL24]
      else $error("channel latched away from output four");

   property p_no_gap_drive;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      r_ff.in_gap |-> !r_ff.drv;
   endproperty
   a_no_gap_drive: assert property (p_no_gap_drive) // [RL15]
      else $error("device pulls the data line inside the gap");
endmodule

// *** verification/mcs_far_end.sv ***
// far-end model: bus clock source plus the other devices on the word slots
`timescale 1ns/1ps
module mcs_far_end (
   input wire logic line_i,
   output logic clk_o,
   output logic pull_o
);
   logic [511:0] cap;
   initial
   begin
      clk_o = 1'h1; // clock stands high outside frames
      pull_o = 1'h0; // released line floats high through the pull-up
      cap = '0;
   end
   // pulses low then high, then a full gap with an optional fault pulse
   task automatic send_frame(input logic ms, input logic [3:0] ch, input logic fault,
      input logic [511:0] pat, input int npulse);
      logic [511:0] p;
      p = pat;
      for (int k = 1; k <= 4; k++)
         p[ms ? 2 * k + 1 : k] = ch[k - 1]; // output k carries channel bit k-1
      for (int i = 0; i < npulse; i++)
      begin
         clk_o = 1'h0;
         pull_o = p[i]; // pulled low means one; two slots per address in ms
         #62.5;
         clk_o = 1'h1;
         // held past the rise so the device samples a settled level
         #20;
         cap[i] = ~line_i;
         pull_o = 1'h0;
         #42.5;
      end
      // 8.5 periods high; fault pulse 3 to 5 periods after the closing rise
      #312.5;
      pull_o = fault;
      #250;
      pull_o = 1'h0;
      #437.5;
   endtask
endmodule

// *** verification/mcs_dev_tb.sv ***
// self-checking bench for the multiplexed-channel device
`timescale 1ns/1ps
module mcs_dev_tb;
   import mcs_pkg::*;
   logic sys_clk_i, reset_n_i, ms_mode_i, src_en_i, mon_on, prev_fault;
   logic far_clk, far_pull, link_w, data_w, prio_en;
   logic [3:0] cha, chb, prio_ch, ch_last;
   logic [NSIG-1:0][3:0] sig_word_i;
   logic [NSIG-1:0] sig_is_out_i, sig_mux_i, rx_upd_o;
   logic [NSIG-1:0][CH_W-1:0] sig_chan_i;
   logic [NSIG-1:0][WORD_W-1:0] tx_word_i, rx_word_o;
   logic data_o, data_oe_n_o, link_clk_o, link_clk_oe_n_o, chan_vld_o, bus_ok_o;
   logic [CH_W-1:0] chan_o;
   logic [15:0] exp_q [NSIG][$];
   int fails, total_checks, t, t1, t2;
   assign link_w = far_clk & (link_clk_oe_n_o | link_clk_o);
   assign data_w = ~far_pull & (data_oe_n_o | data_o);
   mcs_far_end mcs_far_end_i (.line_i(data_w), .clk_o(far_clk), .pull_o(far_pull));
   mcs_dev #(.GAP_DET_CYC(16)) mcs_dev_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .link_clk_i(link_w), .data_i(data_w), .ms_mode_i(ms_mode_i), .src_en_i(src_en_i),
      .ch_last_i(ch_last), .prio_en_i(prio_en), .prio_ch_i(prio_ch), .sig_word_i(sig_word_i),
      .sig_is_out_i(sig_is_out_i), .sig_mux_i(sig_mux_i), .sig_chan_i(sig_chan_i),
      .tx_word_i(tx_word_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
      .link_clk_o(link_clk_o), .link_clk_oe_n_o(link_clk_oe_n_o), .rx_word_o(rx_word_o),
      .rx_upd_o(rx_upd_o), .chan_o(chan_o), .chan_vld_o(chan_vld_o), .bus_ok_o(bus_ok_o));
   initial
   begin
      sys_clk_i = 1'h0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk(input logic ok, input string what);
      total_checks++;
      if (ok !== 1'h1)
      begin
         fails++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // negative edge keeps the sample clear of the register updates
   always @(negedge sys_clk_i)
      if (mon_on)
         for (int s = 0; s < NSIG; s++)
            if (rx_upd_o[s] === 1'h1)
            begin
               if (exp_q[s].size() == 0)
                  chk(1'h0, "update without a pending word");
               else
                  cmp(rx_word_o[s], exp_q[s].pop_front(), "received word");
            end
   task automatic run_frame(input int f, input logic ms, input logic [3:0] ch,
      input logic fault);
      logic [511:0] pat;
      logic [15:0] p1, p2, t0, t3, g0, g3;
      p1 = 16'($urandom);
      p2 = 16'($urandom);
      t0 = 16'($urandom);
      t3 = 16'($urandom);
      pat = '0;
      for (int n = 0; n < 16; n++)
      begin
         pat[ms ? 2 * (32 + n) + 1 : 32 + n] = p1[n];
         pat[ms ? 2 * (48 + n) + 1 : 48 + n] = p2[n];
      end
      exp_q[1].push_back(p1);
      if (ch == cha)
         exp_q[2].push_back(p2);
      @(posedge sys_clk_i);
      ms_mode_i <= ms;
      tx_word_i <= {t3, 16'h0000, 16'h0000, t0};
      @(posedge sys_clk_i);
      fork
         mcs_far_end_i.send_frame(ms, ch, fault, pat, ms ? 160 : 80);
         begin
            repeat (300) @(negedge sys_clk_i);
            chk(chan_o === ch, "channel latched");
            chk(chan_vld_o === 1'h1, "channel valid in frame");
            chk(bus_ok_o === prev_fault, "fault pulse seen");
         end
      join
      chk(chan_vld_o === 1'h0, "channel cleared by gap");
      for (int n = 0; n < 16; n++)
      begin
         g0[n] = mcs_far_end_i.cap[ms ? 2 * (16 + n) : 16 + n];
         g3[n] = mcs_far_end_i.cap[ms ? 2 * (64 + n) : 64 + n];
      end
      cmp(g0, t0, "plain input word");
      cmp(g3, (ch == chb) ? t3 : 16'h0000, "multiplexed input word");
      prev_fault = fault;
      $display("frame %0d channel %0d done", f, ch);
   endtask
   initial
   begin
      {reset_n_i, ms_mode_i, src_en_i, mon_on, prio_en} = 5'h0;
      ch_last = 4'hF;
      prio_ch = 4'h0;
      sig_word_i = '0;
      sig_is_out_i = '0;
      sig_mux_i = '0;
      sig_chan_i = '0;
      tx_word_i = '0;
      fails = 0;
      total_checks = 0;
      void'($urandom(32'h5E13C0AF));
      cha = 4'($urandom_range(15));
      chb = 4'($urandom_range(15));
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'h1;
      sig_word_i <= {4'h4, 4'h3, 4'h2, 4'h1};
      sig_is_out_i <= 4'h6;
      sig_mux_i <= 4'hC; // mux words never share addresses with plain words
      sig_chan_i <= {chb, cha, 4'h0, 4'h0};
      @(negedge sys_clk_i);
      chk(data_oe_n_o === 1'h1 && data_o === 1'h0 && chan_vld_o === 1'h0, "idle after reset");
      @(posedge sys_clk_i);
      mcs_far_end_i.send_frame(1'h0, 4'h0, 1'h1, '0, 0);
      mon_on = 1'h1;
      prev_fault = 1'h1;
      for (int f = 0; f < 9; f++)
         run_frame(f, f >= 6, (f % 3 == 0) ? cha : (f % 3 == 1) ? chb
            : 4'($urandom_range(15)), f != 4);
      repeat (40) @(posedge sys_clk_i);
      for (int s = 0; s < NSIG; s++)
         chk(exp_q[s].size() == 0, "received word missing");
      // second reset with this block as the clock source
      mon_on = 1'h0;
      reset_n_i <= 1'h0;
      src_en_i <= 1'h1;
      ms_mode_i <= 1'h0;
      prio_en <= 1'h1;
      prio_ch <= 4'($urandom_range(15, 1));
      repeat (3) @(posedge sys_clk_i);
      reset_n_i <= 1'h1;
      t = 0;
      t1 = 0;
      t2 = 0;
      while (link_clk_o !== 1'h0 && t < 10000)
      begin
         @(negedge sys_clk_i);
         t++;
         if (data_oe_n_o === 1'h0 && t1 == 0)
            t1 = t;
         if (data_oe_n_o === 1'h1 && t1 != 0 && t2 == 0)
            t2 = t;
      end
      chk(link_clk_oe_n_o === 1'h0, "source drives clock");
      chk(t1 >= 950, "fault pulse delay");
      chk(t2 - t1 >= 1950, "fault pulse length");
      chk(t - t2 >= 1950, "fault pulse recovery");
      chk(t >= 8200 && t <= 8600, "gap length");
      // first frame after reset carries the priority channel; sample mid low half
      repeat (250) @(negedge sys_clk_i);
      for (int k = 1; k <= 4; k++)
      begin
         repeat (1000) @(negedge sys_clk_i);
         chk(link_clk_o === 1'h0 && data_oe_n_o === !prio_ch[k - 1], "channel bit sent");
      end
      $display("clock source gap done");
      close_out();
   end
endmodule
